// file: hw/wtd_pkg.sv
package wtd_pkg;
  // axi byte offsets of the registers
  localparam logic [7:0] WTD_NARROW_CTRL_OFS = 8'h00;
  localparam logic [7:0] WTD_SHARED_CTRL_OFS = 8'h04;
  localparam logic [7:0] WTD_WIDE_CTRL_OFS = 8'h08;
  localparam logic [7:0] WTD_RELOAD_HI_OFS = 8'h0c;
  localparam logic [7:0] WTD_RELOAD_LO_OFS = 8'h10;
  localparam logic [7:0] WTD_CAPTURE_HI_OFS = 8'h14;
  localparam logic [7:0] WTD_CAPTURE_LO_OFS = 8'h18;
  localparam logic [7:0] WTD_NARROW_RELOAD_OFS = 8'h1c;
  // wide / narrow control fields
  localparam int WTD_CTL_OE_BIT = 0;
  localparam int WTD_CTL_IE_BIT = 1;
  localparam int WTD_CTL_DIE_BIT = 2;
  localparam int WTD_CTL_TO_BIT = 5;
  localparam int WTD_CTL_SP_BIT = 6;
  localparam int WTD_CTL_EN_BIT = 7;
  localparam int WTD_CTL_DEMOD_BIT = 3;
  // shared control fields
  localparam int WTD_SH_POL_BIT = 0;
  localparam int WTD_SH_EDGE_R_BIT = 0;
  localparam int WTD_SH_EDGE_F_BIT = 1;
  localparam int WTD_SH_FORCE_LO = 2;
  localparam int WTD_SH_EDGE_LO = 4;
  localparam logic [1:0] WTD_FORCE_ZERO = 2'h2;
  localparam logic [1:0] WTD_FORCE_ONE = 2'h3;
  localparam logic [1:0] WTD_FORCE_PINGPONG = 2'h1;
  localparam logic [1:0] WTD_EDGE_RISE = 2'h1;
  localparam logic [1:0] WTD_EDGE_FALL = 2'h2;
  localparam logic [1:0] WTD_EDGE_BOTH = 2'h3;
  localparam logic [15:0] WTD_CNT_MAX = 16'hffff;
  localparam logic [7:0] WTD_BYTE_ONES = 8'hff;
  localparam logic [7:0] WTD_RESET_BYTE = 8'h00;
  localparam logic [1:0] WTD_RESP_OKAY = 2'h0;
  localparam logic [1:0] WTD_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wtd_wr_t;
endpackage : wtd_pkg

// file: hw/wtd_edge_sync.sv
`timescale 1ns/100ps
module wtd_edge_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel,
  output logic edge_hit
);
  import wtd_pkg::*;
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic rise;
  logic fall;

  // meta_r is read only by sync_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
  // selection codes 01 rise, 10 fall, 11 both; 00 never hits
  assign edge_hit = (edge_sel[WTD_SH_EDGE_R_BIT] & rise) |
                    (edge_sel[WTD_SH_EDGE_F_BIT] & fall);
endmodule : wtd_edge_sync

// file: hw/wtd_timer.sv
`timescale 1ns/100ps
// How it works
// - disabled normal or ping-pong output is inverse of polarity bit
// - force codes 10 and 11 drive output to 0 or 1 always
// - enable loads high*256+low reload and output to polarity
// - at zero: toggle output, interrupt if enabled, set timeout
// - single-pass stops counting at terminal count zero
// - modulo-N reloads the 16-bit value and keeps counting
// - reload bytes rewritable anytime, used only at next load
// - count zero wraps to ffff without timeout
// - edge_interval_capture_mode waits for first selected edge, then reloads and counts
// - later edges store complemented count, reload ffff, restart
// - each capture sets edge status and optional interrupt
// - stop then restart reloads the programmed initial value
// - fixed port: four inputs 0..3, four push-pull outputs 4..7
// - ping-pong hardware hands enable alternately, timeouts set each time
// - output-enable bit routes wide output to port line five
module wtd_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] port_in,
  output logic [3:0] port_in_sync,
  output logic [3:0] port_out,
  output logic wide_irq,
  output logic narrow_irq
);
  import wtd_pkg::*;

  logic [7:0] narrow_ctrl_r;
  logic [7:0] shared_ctrl_r;
  logic [7:0] wide_ctrl_r;
  logic [7:0] reload_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic [7:0] capture_high_byte_r;
  logic [7:0] capture_low_byte_r;
  logic [7:0] narrow_reload_r;
  logic [15:0] wide_cnt_r;
  logic [7:0] narrow_cnt_r;
  logic wide_out_r;
  logic wide_en_d_r;
  logic narrow_en_d_r;
  logic demod_armed_r;
  logic [3:0] in_meta_r;
  logic [3:0] in_sync_r;
  logic wide_irq_r;
  logic narrow_irq_r;
  logic [3:0] port_out_r;

  // write channel holding registers
  logic aw_held_r;
  logic w_held_r;
  wtd_wr_t wr_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wbyte;

  logic edge_hit;
  logic wide_en;
  logic pingpong;
  logic demod;
  logic wide_zero;
  logic wide_tick;
  logic narrow_zero;
  logic narrow_tick;
  logic wide_start;
  logic narrow_start;
  logic [15:0] wide_reload;

  assign wide_en = wide_ctrl_r[WTD_CTL_EN_BIT];
  assign pingpong = shared_ctrl_r[WTD_SH_FORCE_LO +: 2] == WTD_FORCE_PINGPONG;
  assign demod = wide_ctrl_r[WTD_CTL_DEMOD_BIT];
  assign wide_reload = {reload_high_byte_r, reload_low_byte_r};
  assign wide_start = wide_en & ~wide_en_d_r;
  assign narrow_start = narrow_ctrl_r[WTD_CTL_EN_BIT] & ~narrow_en_d_r;
  // counter holds 0001 for one cycle, that cycle is the terminal count
  assign wide_zero = wide_en & ~wide_start & ~demod & wide_cnt_r == 16'h0001;
  assign wide_tick = wide_zero;
  assign narrow_zero = narrow_ctrl_r[WTD_CTL_EN_BIT] & ~narrow_start &
                       narrow_cnt_r == 8'h01;
  assign narrow_tick = narrow_zero;

  wtd_edge_sync u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(port_in[0]),
    .edge_sel(shared_ctrl_r[WTD_SH_EDGE_LO +: 2]),
    .edge_hit(edge_hit)
  );

  // axi write: address and data taken in either order
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_hit = wr_r.strb[0];
  assign wbyte = wr_r.data[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= WTD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        wr_r.addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wr_r.data <= s_axi_wdata;
        wr_r.strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wr_r.addr > WTD_NARROW_RELOAD_OFS || wr_r.addr[1:0] != 2'h0) ?
                   WTD_RESP_SLVERR : WTD_RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready = ~w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // control registers; hardware sets of status win over software clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_ctrl_r <= WTD_RESET_BYTE;
      shared_ctrl_r <= WTD_RESET_BYTE;
      wide_ctrl_r <= WTD_RESET_BYTE;
      reload_high_byte_r <= WTD_RESET_BYTE;
      reload_low_byte_r <= WTD_RESET_BYTE;
      narrow_reload_r <= WTD_RESET_BYTE;
    end else begin
      if (wr_fire && wr_hit) begin
        unique case (wr_r.addr)
          WTD_NARROW_CTRL_OFS: narrow_ctrl_r <= wbyte;
          WTD_SHARED_CTRL_OFS: shared_ctrl_r <= wbyte;
          WTD_WIDE_CTRL_OFS: wide_ctrl_r <= wbyte;
          WTD_RELOAD_HI_OFS: reload_high_byte_r <= wbyte;
          WTD_RELOAD_LO_OFS: reload_low_byte_r <= wbyte;
          WTD_NARROW_RELOAD_OFS: narrow_reload_r <= wbyte;
          default: ;
        endcase
      end
      if (wide_tick) begin
        wide_ctrl_r[WTD_CTL_TO_BIT] <= 1'b1;
        if (wide_ctrl_r[WTD_CTL_SP_BIT] || pingpong) begin
          wide_ctrl_r[WTD_CTL_EN_BIT] <= 1'b0;
        end
        if (pingpong) begin
          narrow_ctrl_r[WTD_CTL_EN_BIT] <= 1'b1;
        end
      end
      if (narrow_tick) begin
        narrow_ctrl_r[WTD_CTL_TO_BIT] <= 1'b1;
        if (narrow_ctrl_r[WTD_CTL_SP_BIT] || pingpong) begin
          narrow_ctrl_r[WTD_CTL_EN_BIT] <= 1'b0;
        end
        if (pingpong) begin
          wide_ctrl_r[WTD_CTL_EN_BIT] <= 1'b1;
        end
      end
      if (demod && wide_en && edge_hit && demod_armed_r) begin
        // edge status bit 0 for rising selections, bit 1 for falling-only
        if (shared_ctrl_r[WTD_SH_EDGE_LO +: 2] == WTD_EDGE_FALL) begin
          shared_ctrl_r[WTD_SH_EDGE_F_BIT] <= 1'b1;
        end else begin
          shared_ctrl_r[WTD_SH_EDGE_R_BIT] <= 1'b1;
        end
      end
    end
  end

  // wide counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_cnt_r <= '0;
      wide_en_d_r <= 1'b0;
      demod_armed_r <= 1'b0;
      capture_high_byte_r <= WTD_RESET_BYTE;
      capture_low_byte_r <= WTD_RESET_BYTE;
    end else begin
      wide_en_d_r <= wide_en;
      if (!wide_en) begin
        demod_armed_r <= 1'b0;
      end else if (wide_start) begin
        wide_cnt_r <= wide_reload;
      end else if (demod) begin
        if (edge_hit) begin
          if (demod_armed_r) begin
            {capture_high_byte_r, capture_low_byte_r} <= ~wide_cnt_r;
          end
          demod_armed_r <= 1'b1;
          wide_cnt_r <= WTD_CNT_MAX;
        end else if (demod_armed_r) begin
          wide_cnt_r <= wide_cnt_r - 16'h0001;
        end
      end else if (wide_tick) begin
        // modulo-N reloads; single-pass leaves zero and stops
        wide_cnt_r <= (wide_ctrl_r[WTD_CTL_SP_BIT] || pingpong) ?
                      16'h0000 : wide_reload;
      end else begin
        // zero wraps to ffff with no timeout, as 0001 is the only tick
        wide_cnt_r <= wide_cnt_r - 16'h0001;
      end
    end
  end

  // narrow counter, only as far as ping-pong hand-off needs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      narrow_cnt_r <= '0;
      narrow_en_d_r <= 1'b0;
    end else begin
      narrow_en_d_r <= narrow_ctrl_r[WTD_CTL_EN_BIT];
      if (narrow_start) begin
        narrow_cnt_r <= narrow_reload_r;
      end else if (narrow_tick) begin
        narrow_cnt_r <= narrow_ctrl_r[WTD_CTL_SP_BIT] ? 8'h00 : narrow_reload_r;
      end else if (narrow_ctrl_r[WTD_CTL_EN_BIT]) begin
        narrow_cnt_r <= narrow_cnt_r - 8'h01;
      end
    end
  end

  // wide output level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_out_r <= 1'b1;
    end else if (shared_ctrl_r[WTD_SH_FORCE_LO +: 2] == WTD_FORCE_ZERO) begin
      wide_out_r <= 1'b0;
    end else if (shared_ctrl_r[WTD_SH_FORCE_LO +: 2] == WTD_FORCE_ONE) begin
      wide_out_r <= 1'b1;
    end else if (!wide_en) begin
      wide_out_r <= ~shared_ctrl_r[WTD_SH_POL_BIT];
    end else if (wide_start) begin
      wide_out_r <= shared_ctrl_r[WTD_SH_POL_BIT];
    end else if (wide_tick) begin
      wide_out_r <= ~wide_out_r;
    end
  end

  // interrupt pulses and port pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_irq_r <= 1'b0;
      narrow_irq_r <= 1'b0;
      port_out_r <= 4'h0;
      in_meta_r <= 4'h0;
      in_sync_r <= 4'h0;
    end else begin
      wide_irq_r <= (wide_tick & wide_ctrl_r[WTD_CTL_IE_BIT]) |
                    (demod & wide_en & edge_hit & demod_armed_r &
                     wide_ctrl_r[WTD_CTL_DIE_BIT]);
      narrow_irq_r <= narrow_tick & narrow_ctrl_r[WTD_CTL_IE_BIT];
      in_meta_r <= port_in;
      in_sync_r <= in_meta_r;
      port_out_r[0] <= 1'b0;
      port_out_r[1] <= wide_ctrl_r[WTD_CTL_OE_BIT] & wide_out_r;
      port_out_r[3:2] <= 2'h0;
    end
  end

  assign port_out = port_out_r;
  assign port_in_sync = in_sync_r;
  assign wide_irq = wide_irq_r;
  assign narrow_irq = narrow_irq_r;

  // axi read, one cycle after arvalid is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= WTD_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= WTD_RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        WTD_NARROW_CTRL_OFS: rdata_r <= {24'h0, narrow_ctrl_r};
        WTD_SHARED_CTRL_OFS: rdata_r <= {24'h0, shared_ctrl_r};
        WTD_WIDE_CTRL_OFS: rdata_r <= {24'h0, wide_ctrl_r};
        WTD_RELOAD_HI_OFS: rdata_r <= {24'h0, reload_high_byte_r};
        WTD_RELOAD_LO_OFS: rdata_r <= {24'h0, reload_low_byte_r};
        WTD_CAPTURE_HI_OFS: rdata_r <= {24'h0, capture_high_byte_r};
        WTD_CAPTURE_LO_OFS: rdata_r <= {24'h0, capture_low_byte_r};
        WTD_NARROW_RELOAD_OFS: rdata_r <= {24'h0, narrow_reload_r};
        default: begin
          rdata_r <= '0;
          rresp_r <= WTD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  disable_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wide_en && shared_ctrl_r[3] == 1'b0 && $stable(shared_ctrl_r) && !pingpong) |=>
      wide_out_r == ~$past(shared_ctrl_r[WTD_SH_POL_BIT]))
    else $error("disabled output wrong");
  force_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (shared_ctrl_r[3] && $stable(shared_ctrl_r)) |=> wide_out_r == $past(shared_ctrl_r[2]))
    else $error("forced output wrong");
  start_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wide_start |=> wide_cnt_r == $past(wide_reload))
    else $error("start load wrong");
  timeout_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wide_tick |=> wide_ctrl_r[WTD_CTL_TO_BIT])
    else $error("timeout bit not set");
  single_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wide_tick && wide_ctrl_r[WTD_CTL_SP_BIT] && !narrow_tick) |=> !wide_en)
    else $error("single pass not stopped");
  modn_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wide_tick && !wide_ctrl_r[WTD_CTL_SP_BIT] && !pingpong) |=>
      wide_cnt_r == $past(wide_reload))
    else $error("modulo reload wrong");
  wrap_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wide_en && !demod && !wide_start && wide_cnt_r == 16'h0000) |-> !wide_tick)
    else $error("wrap counted as timeout");
  capture_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (demod && wide_en && !wide_start && edge_hit && demod_armed_r) |=>
      {capture_high_byte_r, capture_low_byte_r} == ~$past(wide_cnt_r) &&
      wide_cnt_r == WTD_CNT_MAX)
    else $error("capture wrong");
  port_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 port_out[1] == $past(wide_ctrl_r[WTD_CTL_OE_BIT] & wide_out_r))
    else $error("port line wrong");
  tick_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) wide_tick);
  capture_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    demod && edge_hit && demod_armed_r);
  handoff_cov_c: cover property (@(posedge aclk) disable iff (!aresetn)
    pingpong && narrow_tick);
endmodule : wtd_timer

// file: dv/wtd_pulse_src.sv
`timescale 1ns/100ps
module wtd_pulse_src (
  input wire logic aclk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic sig
);
  logic [7:0] cnt_r;
  // idles low between bursts, so the first edge of a burst is a rise
  always_ff @(posedge aclk) begin
    if (!run) begin
      cnt_r <= 8'h01;
      sig <= 1'b0;
    end else if (cnt_r == half) begin
      cnt_r <= 8'h01;
      sig <= ~sig;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : wtd_pulse_src

// file: dv/tb_wide_timer_transmit_demod.sv
`timescale 1ns/100ps
module tb_wide_timer_transmit_demod;
  import wtd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wide_irq, narrow_irq, pulse;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [3:0] port_in_sync, port_out;
  logic [2:0] port_hi = 3'h0;
  logic run = 1'b0;
  logic [7:0] half = 8'h14;
  logic [15:0] cap;
  logic got;
  int cyc;
  int error_cnt = 0;
  int checks_done = 0;

  always #2.5 aclk = ~aclk;

  wtd_pulse_src u_wtd_pulse_src (.aclk(aclk), .run(run), .half(half), .sig(pulse));

  wtd_timer u_wtd_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_in({port_hi, pulse}), .port_in_sync(port_in_sync), .port_out(port_out),
    .wide_irq(wide_irq), .narrow_irq(narrow_irq)
  );

  task wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task hang;
    error_cnt++;
    $display("wrong value at %0t: no answer in time", $time);
    wrap_up();
  endtask : hang

  task near(input int seen, input int exp, input int tol);
    check(32'((seen >= exp - tol) && (seen <= exp + tol)), 32'h1);
  endtask : near

  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 50) hang();
  endtask : wr

  task rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 50) hang();
  endtask : rd_reg

  task wait_ev(input logic nar, input int lim);
    cyc = 0;
    got = 1'b0;
    while (!got && cyc < lim) begin
      @(posedge aclk);
      cyc++;
      got = ((nar ? narrow_irq : wide_irq) === 1'b1);
    end
  endtask : wait_ev

  task must_ev(input logic nar, input int lim);
    wait_ev(nar, lim);
    if (!got) hang();
  endtask : must_ev

  task settle;
    repeat (3) @(posedge aclk);
  endtask : settle

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(WTD_WIDE_CTRL_OFS);
    check(rd, 32'h0);
    check(32'(rs), 32'(WTD_RESP_OKAY));
    rd_reg(8'h20);
    check(32'(rs), 32'(WTD_RESP_SLVERR));
    check(rd, 32'h0);
    // unmapped write is refused; a write without the low lane is dropped
    wr(8'h22, 8'h00);
    check(32'(rs), 32'(WTD_RESP_SLVERR));
    wstrb <= 4'h0;
    wr(WTD_RELOAD_HI_OFS, 8'h5a);
    check(32'(rs), 32'(WTD_RESP_OKAY));
    wstrb <= 4'hf;
    rd_reg(WTD_RELOAD_HI_OFS);
    check(rd, 32'h0);
    port_hi <= 3'h5;
    settle();
    settle();
    check(32'(port_in_sync[3:1]), 32'h5);
    check(32'({port_out[3:2], port_out[0]}), 32'h0);
    // disabled level, then forcing
    wr(WTD_SHARED_CTRL_OFS, 8'h00);
    wr(WTD_WIDE_CTRL_OFS, 8'h01);
    settle();
    check(32'(port_out[1]), 32'h1);
    wr(WTD_SHARED_CTRL_OFS, 8'h01);
    settle();
    check(32'(port_out[1]), 32'h0);
    wr(WTD_SHARED_CTRL_OFS, 8'h08);
    settle();
    check(32'(port_out[1]), 32'h0);
    wr(WTD_SHARED_CTRL_OFS, 8'h0d);
    settle();
    check(32'(port_out[1]), 32'h1);
    wr(WTD_WIDE_CTRL_OFS, 8'h00);
    settle();
    check(32'(port_out[1]), 32'h0);
    // modulo-N with a reload rewrite in mid-run
    wr(WTD_RELOAD_HI_OFS, 8'h00);
    wr(WTD_RELOAD_LO_OFS, 8'h10);
    wr(WTD_SHARED_CTRL_OFS, 8'h00);
    wr(WTD_WIDE_CTRL_OFS, 8'h83);
    settle();
    check(32'(port_out[1]), 32'h0);
    must_ev(1'b0, 100);
    settle();
    check(32'(port_out[1]), 32'h1);
    must_ev(1'b0, 100);
    must_ev(1'b0, 100);
    near(cyc, 16, 1);
    wr(WTD_RELOAD_LO_OFS, 8'h20);
    must_ev(1'b0, 100);
    must_ev(1'b0, 100);
    near(cyc, 32, 1);
    rd_reg(WTD_WIDE_CTRL_OFS);
    check(32'(rd[5]), 32'h1);
    // single-pass, then stop and restart
    wr(WTD_RELOAD_LO_OFS, 8'h10);
    wr(WTD_WIDE_CTRL_OFS, 8'h42);
    wr(WTD_WIDE_CTRL_OFS, 8'hc2);
    must_ev(1'b0, 100);
    wait_ev(1'b0, 100);
    check(32'(got), 32'h0);
    wr(WTD_WIDE_CTRL_OFS, 8'h42);
    wr(WTD_WIDE_CTRL_OFS, 8'hc2);
    wait_ev(1'b0, 40);
    check(32'(got), 32'h1);
    // count of zero wraps without a timeout
    wr(WTD_RELOAD_LO_OFS, 8'h00);
    wr(WTD_WIDE_CTRL_OFS, 8'h42);
    wr(WTD_WIDE_CTRL_OFS, 8'hc2);
    wait_ev(1'b0, 300);
    check(32'(got), 32'h0);
    rd_reg(WTD_WIDE_CTRL_OFS);
    check(32'(rd[5]), 32'h0);
    // ping-pong start sequence
    wr(WTD_WIDE_CTRL_OFS, 8'h00);
    wr(WTD_NARROW_CTRL_OFS, 8'h00);
    wr(WTD_NARROW_RELOAD_OFS, 8'h08);
    wr(WTD_RELOAD_LO_OFS, 8'h10);
    wr(WTD_NARROW_CTRL_OFS, 8'h42);
    wr(WTD_WIDE_CTRL_OFS, 8'h42);
    wr(WTD_SHARED_CTRL_OFS, 8'h04);
    wr(WTD_WIDE_CTRL_OFS, 8'hc2);
    must_ev(1'b0, 100);
    wait_ev(1'b1, 60);
    check(32'(got), 32'h1);
    wait_ev(1'b0, 60);
    check(32'(got), 32'h1);
    rd_reg(WTD_NARROW_CTRL_OFS);
    check(32'(rd[5]), 32'h1);
    wr(WTD_SHARED_CTRL_OFS, 8'h00);
    wr(WTD_WIDE_CTRL_OFS, 8'h00);
    wr(WTD_NARROW_CTRL_OFS, 8'h00);
    // edge interval capture for edge select codes 01, 10 and 11
    for (int m = 1; m < 4; m++) begin
      wr(WTD_RELOAD_HI_OFS, WTD_BYTE_ONES);
      wr(WTD_RELOAD_LO_OFS, WTD_BYTE_ONES);
      wr(WTD_SHARED_CTRL_OFS, {2'h0, m[1:0], 4'h0});
      wr(WTD_WIDE_CTRL_OFS, 8'h8c);
      run <= 1'b1;
      must_ev(1'b0, 400);
      near(cyc, (m == 2) ? 80 : ((m == 3) ? 40 : 60), 12);
      rd_reg(WTD_CAPTURE_HI_OFS);
      cap[15:8] = rd[7:0];
      rd_reg(WTD_CAPTURE_LO_OFS);
      cap[7:0] = rd[7:0];
      near(int'(cap), (m == 3) ? 20 : 40, 2);
      rd_reg(WTD_SHARED_CTRL_OFS);
      check(32'(m == 1 ? rd[0] : (m == 2 ? rd[1] : |rd[1:0])), 32'h1);
      run <= 1'b0;
      wr(WTD_WIDE_CTRL_OFS, 8'h00);
    end
    wrap_up();
  end
endmodule : tb_wide_timer_transmit_demod
